// file: hdl/cwcfg_regs.sv
// What this block does
// - The four channel configuration bytes sit at ascending byte addresses, A through D.
// - Reset clears every configuration byte to zero.
// - Bit 7 picks window (0) or plain comparator (1) operation and drives the mode output.
// - Above 1 V nominal, bits 6:3 shift the window from +3% at code 0 down to -4% at code 7.
// - At 1 V nominal, bits 6:3 pick an absolute threshold from 1.05 V down to 0.7 V.
// - Bits 2:0 pick the nominal window level.
// - All fields are read/write and a read returns the last value written, with no side effect.
module cwcfg_regs #(
    parameter int unsigned NUM_CHAN = cwcfg_pkg::NUM_CHAN
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    output logic reg_addr_error,
    output logic [NUM_CHAN-1:0] chan_op_select,
    output logic [NUM_CHAN*3-1:0] chan_level_select,
    output logic [NUM_CHAN*4-1:0] chan_window_shift,
    output logic [NUM_CHAN*16-1:0] chan_threshold_mv,
    output logic [NUM_CHAN*8-1:0] chan_shift_pct,
    output logic [NUM_CHAN-1:0] chan_shift_reserved
);
    // Returns the channel index of an address, or NUM_CHAN when unmapped.
    function automatic int unsigned cwcfg_chan_of(input logic [7:0] addr);
        int unsigned idx;
        idx = NUM_CHAN;
        if (addr >= cwcfg_pkg::COMPARATOR_A_WINDOW_CONFIG &&
            addr <= cwcfg_pkg::COMPARATOR_D_WINDOW_CONFIG) begin
            idx = 32'(addr - cwcfg_pkg::COMPARATOR_A_WINDOW_CONFIG);
        end
        cwcfg_chan_of = idx;
    endfunction : cwcfg_chan_of

    logic [7:0] config_mem [NUM_CHAN];
    logic [7:0] next_config_mem [NUM_CHAN];
    logic [7:0] next_reg_rdata;
    logic next_reg_addr_error;

    always_comb begin
        int unsigned widx;
        int unsigned ridx;
        widx = cwcfg_chan_of(reg_addr);
        ridx = widx;
        for (int i = 0; i < NUM_CHAN; i++) begin
            next_config_mem[i] = config_mem[i];
        end
        // All eight bits stored verbatim, reserved shift codes included.
        if (reg_write && widx < NUM_CHAN) begin
            next_config_mem[widx] = reg_wdata;
        end
        // Read data stand only in the cycle after the strobe; zero otherwise.
        next_reg_rdata = 8'h00;
        next_reg_addr_error = 1'b0;
        if (reg_read) begin
            if (ridx < NUM_CHAN) begin
                next_reg_rdata = config_mem[ridx];
            end else begin
                next_reg_addr_error = 1'b1;
            end
        end
        if (reg_write && widx >= NUM_CHAN) begin
            next_reg_addr_error = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                config_mem[i] <= cwcfg_pkg::CONFIG_RESET;
            end
            reg_rdata <= 8'h00;
            reg_addr_error <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_CHAN; i++) begin
                config_mem[i] <= next_config_mem[i];
            end
            reg_rdata <= next_reg_rdata;
            reg_addr_error <= next_reg_addr_error;
        end
    end

    // Decoders read the stored bytes directly, so outputs follow a write by one edge.
    for (genvar g = 0; g < NUM_CHAN; g++) begin : g_chan
        cwcfg_decode u_decode (
            .config_byte(config_mem[g]),
            .op_select(chan_op_select[g]),
            .level_select(chan_level_select[g*3 +: 3]),
            .window_shift(chan_window_shift[g*4 +: 4]),
            .nominal_mv(),
            .threshold_mv(chan_threshold_mv[g*16 +: 16]),
            .shift_pct(chan_shift_pct[g*8 +: 8]),
            .shift_reserved(chan_shift_reserved[g])
        );
    end
endmodule : cwcfg_regs

// file: common/cwcfg_pkg.sv
package cwcfg_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NUM_CHAN = 4;

    // Byte addresses, channel A through D.
    localparam logic [7:0] COMPARATOR_A_WINDOW_CONFIG = 8'hDD;
    localparam logic [7:0] COMPARATOR_B_WINDOW_CONFIG = 8'hDE;
    localparam logic [7:0] COMPARATOR_C_WINDOW_CONFIG = 8'hDF;
    localparam logic [7:0] COMPARATOR_D_WINDOW_CONFIG = 8'hE0;

    localparam logic [7:0] CONFIG_RESET = 8'h00;

    // Field layout.
    localparam int unsigned OP_SELECT_BIT = 7;
    localparam int unsigned SHIFT_MSB = 6;
    localparam int unsigned SHIFT_LSB = 3;
    localparam int unsigned LEVEL_MSB = 2;
    localparam int unsigned LEVEL_LSB = 0;

    // Operation select values.
    localparam logic OP_WINDOW = 1'b0;
    localparam logic OP_COMPARATOR = 1'b1;

    // Nominal level select codes.
    localparam logic [2:0] LEVEL_1V00 = 3'h0;
    localparam logic [2:0] LEVEL_1V20 = 3'h1;
    localparam logic [2:0] LEVEL_1V50 = 3'h2;
    localparam logic [2:0] LEVEL_1V80 = 3'h3;
    localparam logic [2:0] LEVEL_1V10 = 3'h4;
    localparam logic [2:0] LEVEL_1V35 = 3'h5;
    localparam logic [2:0] LEVEL_3V30 = 3'h6;
    localparam logic [2:0] LEVEL_HIGH = 3'h7;

    // Highest shift code with a defined meaning; above it is reserved.
    localparam logic [3:0] SHIFT_PCT_MAX = 4'h7;
    localparam logic [3:0] SHIFT_ABS_MAX = 4'h9;

    // Threshold in millivolts, 16 bits wide; 0 marks a reserved code.
    localparam int unsigned MV_W = 16;
    localparam logic [15:0] MV_RESERVED = 16'h0000;
    // Percent shift as a signed value; +3 at code 0, one lower per step.
    localparam logic signed [7:0] PCT_AT_ZERO = 8'sh03;
endpackage : cwcfg_pkg

// file: hdl/cwcfg_decode.sv
// Turns one channel's configuration byte into the analog trim controls.
module cwcfg_decode (
    input wire logic [7:0] config_byte,
    output logic op_select,
    output logic [2:0] level_select,
    output logic [3:0] window_shift,
    output logic [15:0] nominal_mv,
    output logic [15:0] threshold_mv,
    output logic signed [7:0] shift_pct,
    output logic shift_reserved
);
    function automatic logic [15:0] cwcfg_level_mv(input logic [2:0] code);
        unique case (code)
            cwcfg_pkg::LEVEL_1V00: cwcfg_level_mv = 16'h03E8;
            cwcfg_pkg::LEVEL_1V20: cwcfg_level_mv = 16'h04B0;
            cwcfg_pkg::LEVEL_1V50: cwcfg_level_mv = 16'h05DC;
            cwcfg_pkg::LEVEL_1V80: cwcfg_level_mv = 16'h0708;
            cwcfg_pkg::LEVEL_1V10: cwcfg_level_mv = 16'h044C;
            cwcfg_pkg::LEVEL_1V35: cwcfg_level_mv = 16'h0546;
            cwcfg_pkg::LEVEL_3V30: cwcfg_level_mv = 16'h0CE4;
            // 2.5 V or 5 V depends on the channel's assembly; 2.5 V reported.
            cwcfg_pkg::LEVEL_HIGH: cwcfg_level_mv = 16'h09C4;
        endcase
    endfunction : cwcfg_level_mv

    function automatic logic [15:0] cwcfg_abs_mv(input logic [3:0] code);
        case (code)
            4'h0: cwcfg_abs_mv = 16'h041A;
            4'h1: cwcfg_abs_mv = 16'h03E8;
            4'h2: cwcfg_abs_mv = 16'h03CF;
            4'h3: cwcfg_abs_mv = 16'h03B6;
            4'h4: cwcfg_abs_mv = 16'h0384;
            4'h5: cwcfg_abs_mv = 16'h036B;
            4'h6: cwcfg_abs_mv = 16'h0352;
            4'h7: cwcfg_abs_mv = 16'h0320;
            4'h8: cwcfg_abs_mv = 16'h02EE;
            4'h9: cwcfg_abs_mv = 16'h02BC;
            default: cwcfg_abs_mv = cwcfg_pkg::MV_RESERVED;
        endcase
    endfunction : cwcfg_abs_mv

    always_comb begin
        op_select = config_byte[cwcfg_pkg::OP_SELECT_BIT];
        level_select = config_byte[cwcfg_pkg::LEVEL_MSB:cwcfg_pkg::LEVEL_LSB];
        window_shift = config_byte[cwcfg_pkg::SHIFT_MSB:cwcfg_pkg::SHIFT_LSB];
        nominal_mv = cwcfg_level_mv(level_select);
        shift_pct = 8'sh00;
        threshold_mv = cwcfg_pkg::MV_RESERVED;
        shift_reserved = 1'b0;
        if (level_select == cwcfg_pkg::LEVEL_1V00) begin
            threshold_mv = cwcfg_abs_mv(window_shift);
            shift_reserved = (window_shift > cwcfg_pkg::SHIFT_ABS_MAX);
        end else if (window_shift <= cwcfg_pkg::SHIFT_PCT_MAX) begin
            shift_pct = cwcfg_pkg::PCT_AT_ZERO - $signed({4'h0, window_shift});
            threshold_mv = nominal_mv;
        end else begin
            shift_reserved = 1'b1;
        end
    end
endmodule : cwcfg_decode

// file: test/cwcfg_regs_props.sv
module cwcfg_regs_checker #(
    parameter int unsigned NUM_CHAN = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [NUM_CHAN-1:0] chan_op_select,
    input wire logic [NUM_CHAN*3-1:0] chan_level_select,
    input wire logic [NUM_CHAN*4-1:0] chan_window_shift
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_rd_idle;
        !reg_read |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");
    property p_op_a;
        reg_write && reg_addr == 8'hDD |=> chan_op_select[0] == $past(reg_wdata[7]);
    endproperty
    a_op_a: assert property (p_op_a) else $error("mode A not updated");
    property p_lvl_b;
        reg_write && reg_addr == 8'hDE |=> chan_level_select[5:3] == $past(reg_wdata[2:0]);
    endproperty
    a_lvl_b: assert property (p_lvl_b) else $error("level B not updated");
    property p_shf_d;
        reg_write && reg_addr == 8'hE0 |=> chan_window_shift[15:12] == $past(reg_wdata[6:3]);
    endproperty
    a_shf_d: assert property (p_shf_d) else $error("shift D not updated");
    property p_rd_c;
        reg_read && reg_addr == 8'hDF |=>
            reg_rdata == {chan_op_select[2], chan_window_shift[11:8], chan_level_select[8:6]};
    endproperty
    a_rd_c: assert property (p_rd_c) else $error("read C mismatch");
    property p_hold;
        !reg_write |=> $stable(chan_window_shift) && $stable(chan_op_select);
    endproperty
    a_hold: assert property (p_hold) else $error("fields changed without write");
    property p_unmapped;
        reg_write && reg_addr == 8'hE1 |=> $stable(chan_level_select);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped write took effect");
    property p_wr_rd;
        reg_write && reg_addr == 8'hDD ##1 !reg_write ##1 reg_read && reg_addr == 8'hDD |=>
            reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("read after write mismatch");
endmodule : cwcfg_regs_checker

bind cwcfg_regs cwcfg_regs_checker #(.NUM_CHAN(NUM_CHAN)) i_cwcfg_regs_checker (
    .clk(clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .chan_op_select(chan_op_select),
    .chan_level_select(chan_level_select),
    .chan_window_shift(chan_window_shift)
);

// file: test/cwcfg_regs_tb.sv
module cwcfg_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'h0;
    logic reg_read = 1'h0;
    logic [7:0] reg_rdata, d;
    logic reg_addr_error;
    logic [3:0] op_sel, shf_rsv;
    logic [11:0] lvl;
    logic [15:0] shf;
    logic [63:0] thr_mv;
    logic [31:0] pct;
    int n_fail = 0;
    int check_count = 0;
    logic [15:0] abs_mv [10] = '{16'h041A, 16'h03E8, 16'h03CF, 16'h03B6, 16'h0384,
        16'h036B, 16'h0352, 16'h0320, 16'h02EE, 16'h02BC};
    logic [15:0] nom_mv [8] = '{16'h03E8, 16'h04B0, 16'h05DC, 16'h0708, 16'h044C,
        16'h0546, 16'h0CE4, 16'h09C4};
    always #25 clk = ~clk;
    cwcfg_regs i_cwcfg_regs (
        .clk(clk),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_read(reg_read),
        .reg_rdata(reg_rdata),
        .reg_addr_error(reg_addr_error),
        .chan_op_select(op_sel),
        .chan_level_select(lvl),
        .chan_window_shift(shf),
        .chan_threshold_mv(thr_mv),
        .chan_shift_pct(pct),
        .chan_shift_reserved(shf_rsv)
    );
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_write <= 1'h1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_write <= 1'h0;
        #1;
        cmp("write address error", {15'h0000, a < 8'hDD || a > 8'hE0}, {15'h0000, reg_addr_error});
    endtask : wr
    // Address error is expected exactly when the address falls outside the four channels.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_read <= 1'h1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'h0;
        #1;
        cmp("read data", {8'h00, exp}, {8'h00, reg_rdata});
        cmp("address error", {15'h0000, a < 8'hDD || a > 8'hE0}, {15'h0000, reg_addr_error});
    endtask : rd
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #1000000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        for (int i = 0; i < 4; i++) rd(8'(8'hDD + i), 8'h00);
        for (int i = 0; i < 4; i++) begin
            d = 8'(8'hC9 - 8'h25 * i);
            wr(8'(8'hDD + i), d);
            cmp("mode", {15'h0000, d[7]}, {15'h0000, op_sel[i]});
            cmp("level", {13'h0000, d[2:0]}, {13'h0000, lvl[3*i+:3]});
            cmp("shift", {12'h000, d[6:3]}, {12'h000, shf[4*i+:4]});
        end
        for (int i = 0; i < 4; i++) rd(8'(8'hDD + i), 8'(8'hC9 - 8'h25 * i));
        for (int k = 0; k < 10; k++) begin
            wr(8'hDD, {1'h0, 4'(k), 3'h0});
            cmp("absolute threshold", abs_mv[k], thr_mv[15:0]);
        end
        wr(8'hDD, 8'h50);
        rd(8'hDD, 8'h50);
        cmp("reserved", 16'h0001, {15'h0000, shf_rsv[0]});
        for (int k = 0; k < 8; k++) begin
            wr(8'hDE, {1'h0, 4'(k), 3'h1});
            cmp("shift percent", {8'h00, 8'(3 - k)}, {8'h00, pct[15:8]});
        end
        // Undefined shift code above a 1 V nominal: flagged, threshold and shift percent zero, mode and level as written.
        wr(8'hDE, 8'hE6);
        cmp("reserved B", 16'h0001, {15'h0000, shf_rsv[1]});
        cmp("level B", 16'h0006, {13'h0000, lvl[5:3]});
        cmp("mode B", 16'h0001, {15'h0000, op_sel[1]});
        cmp("threshold B", 16'h0000, thr_mv[31:16]);
        cmp("shift percent B", 16'h0000, {8'h00, pct[15:8]});
        for (int v = 1; v < 8; v++) begin
            wr(8'hDF, {5'h00, 3'(v)});
            cmp("nominal", nom_mv[v], thr_mv[47:32]);
        end
        wr(8'hE1, 8'hFF);
        rd(8'hE1, 8'h00);
        rd(8'hDC, 8'h00);
        rd(8'hDF, 8'h07);
        // A reset in mid-run must clear bytes that now hold non-zero values.
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        cmp("mode after reset", 16'h0000, {12'h000, op_sel});
        cmp("threshold after reset", 16'h041A, thr_mv[15:0]);
        for (int i = 0; i < 4; i++) rd(8'(8'hDD + i), 8'h00);
        tally_and_finish();
    end
endmodule : cwcfg_regs_tb
